// file: core/scm_clock_mode_ctrl.sv
// system clock selection, oscillator ready flags and halt mode control
//
// Overview of operation
// RL1 - the fast oscillator starts at 8 MHz and software can select 8, 12 or 16 MHz.
// RL2 - frequency code 00 is 8 MHz, 01 is 16 MHz, 10 is 12 MHz, 11 is 8 MHz, reset 00.
// RL3 - the 32 kHz slow oscillator runs from power-on and no bit can stop it.
// RL4 - the slow clock also feeds the watchdog, the time base and the timer.
// RL5 - with direct fast off, divider codes 000/001 give slow, 010..111 give fast/64 down to fast/2.
// RL6 - direct fast on runs the system from the undivided fast clock.
// RL7 - the fast ready flag is cleared at power-on and rises once the fast oscillator is stable.
// RL8 - the fast ready flag is low in sleep and clock-stopped idle and rises 15 to 16 cycles after wake-up.
// RL9 - the slow ready flag reads 0 until the slow oscillator is stable, both ready flags are read-only.
// RL10 - with idle select high a halt stops the cpu, idle clock keep decides whether the system clock runs.
// RL11 - with idle select low a halt enters sleep.
// RL12 - there are five modes, normal and slow run the cpu, sleep and two idles stop it.
// RL13 - the spare mode bit is a plain read/write bit resetting to 0.
// RL14 - software keeps the two low bits of the frequency control register unchanged.
// RL15 - bits 6, 3 and 2 of the frequency control register read as 0.
// RL16 - clock source and ratio changes make no runt pulses on the system clock.
// RL17 - the mode register resets with divider 000, spare 0, flags 0, idle select 1, direct fast 1.
module scm_clock_mode_ctrl
  import scm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu and oscillator status
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic slow_osc_stable,
  input wire logic fast_osc_stable,
  input wire logic pin_reset_evt,
  // clock outputs
  output logic sys_clk_en_r,
  output logic slow_clk_en_r,
  output logic [1:0] fast_freq_r,
  output logic fast_osc_en_r,
  output scm_mode_t mode_r,
  output scm_clk_stat_t clk_stat_r
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [2:0] slow_sync_r;
  logic [2:0] fast_sync_r;
  logic slow_ok_r;
  logic fast_ok_r;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slow_sync_r <= 3'h0;
      fast_sync_r <= 3'h0;
      slow_ok_r <= 1'b0;
      fast_ok_r <= 1'b0;
    end else begin
      slow_sync_r <= {slow_sync_r[1:0], slow_osc_stable};
      fast_sync_r <= {fast_sync_r[1:0], fast_osc_stable};
      if (slow_sync_r[1] == slow_sync_r[2]) begin
        slow_ok_r <= slow_sync_r[2];
      end
      if (fast_sync_r[1] == fast_sync_r[2]) begin
        fast_ok_r <= fast_sync_r[2];
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [1:0] freq_sel_r;
  logic [1:0] fc_rsv_r;
  logic pin_reset_r;
  logic [2:0] div_sel_r;
  logic spare_r;
  logic idle_sel_r;
  logic direct_fast_r;
  logic idle_keep_r;
  logic slow_rdy_r;
  logic fast_rdy_r;
  logic ack_r;
  logic wr_go;
  logic rd_go;
  assign wr_go = avs_write && ack_r;
  assign rd_go = avs_read && !ack_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      freq_sel_r <= SCM_FC_SEL_RST; // RL1 RL2
      fc_rsv_r <= SCM_FC_RSV_RST;
      div_sel_r <= SCM_MD_DIV_RST; // RL17
      spare_r <= SCM_MD_SPARE_RST; // RL13
      idle_sel_r <= SCM_MD_IDLE_SEL_RST; // RL17
      direct_fast_r <= SCM_MD_DIRECT_RST; // RL17
      idle_keep_r <= SCM_IDLE_KEEP_RST;
    end else if (wr_go && avs_byteenable[0]) begin
      case (avs_address)
        SCM_ADDR_FREQ_CTRL: begin
          freq_sel_r <= avs_writedata[SCM_FC_SEL_LO_POS +: 2]; // RL1
          fc_rsv_r <= avs_writedata[1:0];
        end
        SCM_ADDR_MODE: begin
          div_sel_r <= avs_writedata[SCM_MD_DIV_LO_POS +: 3];
          spare_r <= avs_writedata[SCM_MD_SPARE_POS]; // RL13
          idle_sel_r <= avs_writedata[SCM_MD_IDLE_SEL_POS];
          direct_fast_r <= avs_writedata[SCM_MD_DIRECT_POS];
        end
        SCM_ADDR_AUX: begin
          idle_keep_r <= avs_writedata[0];
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin reset flag, set wins over software clear
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_reset_r <= SCM_FC_PIN_RESET_RST;
    end else if (pin_reset_evt) begin
      pin_reset_r <= 1'b1;
    end else if (wr_go && avs_byteenable[0] && avs_address == SCM_ADDR_FREQ_CTRL) begin
      pin_reset_r <= avs_writedata[SCM_FC_PIN_RESET_POS];
    end
  end

  // ------------------------------------------------------------
  // bus answer: one wait cycle, then ack
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (rd_go) begin
        case (avs_address)
          SCM_ADDR_FREQ_CTRL: avs_readdata <= {24'h0, pin_reset_r, 1'b0, freq_sel_r, 2'h0, fc_rsv_r}; // RL15 RL14
          SCM_ADDR_MODE: avs_readdata <= {24'h0, div_sel_r, spare_r, slow_rdy_r, fast_rdy_r,
                                          idle_sel_r, direct_fast_r}; // RL9
          SCM_ADDR_AUX: avs_readdata <= {31'h0, idle_keep_r};
          SCM_ADDR_STATUS: avs_readdata <= {29'h0, mode_r};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end
  // waitrequest is low only in the cycle after a request is taken
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // ------------------------------------------------------------
  // operating mode
  // ------------------------------------------------------------
  logic slow_sel;
  assign slow_sel = !direct_fast_r && (div_sel_r[2:1] == 2'b00); // RL5 RL6
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_r <= SCM_MODE_NORMAL;
    end else begin
      case (mode_r)
        SCM_MODE_NORMAL, SCM_MODE_SLOW: begin // RL12
          if (halt_req) begin
            if (!idle_sel_r) begin
              mode_r <= SCM_MODE_SLEEP; // RL11
            end else if (idle_keep_r) begin
              mode_r <= SCM_MODE_IDLE_RUN; // RL10
            end else begin
              mode_r <= SCM_MODE_IDLE_STOP; // RL10
            end
          end else begin
            mode_r <= slow_sel ? SCM_MODE_SLOW : SCM_MODE_NORMAL;
          end
        end
        SCM_MODE_IDLE_STOP, SCM_MODE_IDLE_RUN, SCM_MODE_SLEEP: begin
          if (wake_req) begin
            mode_r <= slow_sel ? SCM_MODE_SLOW : SCM_MODE_NORMAL;
          end
        end
        default: mode_r <= SCM_MODE_NORMAL;
      endcase
    end
  end

  // ------------------------------------------------------------
  // ready flags
  // ------------------------------------------------------------
  logic [4:0] wake_cnt_r;
  logic clk_stopped;
  assign clk_stopped = (mode_r == SCM_MODE_SLEEP) || (mode_r == SCM_MODE_IDLE_STOP);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slow_rdy_r <= 1'b0;
      fast_rdy_r <= 1'b0;
      wake_cnt_r <= 5'h0;
    end else begin
      slow_rdy_r <= slow_rdy_r || slow_ok_r; // RL9
      if (clk_stopped) begin
        fast_rdy_r <= 1'b0; // RL8
        wake_cnt_r <= SCM_FAST_WAKE_CYC;
      end else if (wake_cnt_r != 5'h0) begin
        wake_cnt_r <= wake_cnt_r - 5'h1; // RL8
        fast_rdy_r <= 1'b0;
      end else begin
        fast_rdy_r <= fast_ok_r; // RL7
      end
    end
  end

  // ------------------------------------------------------------
  // system clock divider and glitch-free enable
  // ------------------------------------------------------------
  logic [5:0] div_cnt_r;
  logic [5:0] div_mask;
  always_comb begin
    case (div_sel_r)
      3'h2: div_mask = 6'h3f;
      3'h3: div_mask = 6'h1f;
      3'h4: div_mask = 6'h0f;
      3'h5: div_mask = 6'h07;
      3'h6: div_mask = 6'h03;
      3'h7: div_mask = 6'h01;
      default: div_mask = 6'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_cnt_r <= 6'h0;
      sys_clk_en_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_r + 6'h1;
      // one-cycle enables only, so a ratio change never shortens a pulse
      if (clk_stopped) begin
        sys_clk_en_r <= 1'b0; // RL10
      end else if (direct_fast_r) begin
        sys_clk_en_r <= 1'b1; // RL6 RL16
      end else if (slow_sel) begin
        sys_clk_en_r <= 1'b0; // RL5
      end else begin
        sys_clk_en_r <= (div_cnt_r & div_mask) == div_mask; // RL5 RL16
      end
    end
  end

  // ------------------------------------------------------------
  // oscillator controls
  // ------------------------------------------------------------
  logic [1:0] freq_dec;
  always_comb begin
    case (freq_sel_r)
      SCM_FREQ_16M: freq_dec = SCM_FREQ_16M; // RL2
      SCM_FREQ_12M: freq_dec = SCM_FREQ_12M; // RL2
      default: freq_dec = SCM_FREQ_8M; // RL2
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slow_clk_en_r <= 1'b0;
      fast_freq_r <= SCM_FREQ_8M;
      fast_osc_en_r <= 1'b0;
    end else begin
      slow_clk_en_r <= 1'b1; // RL3 RL4
      fast_freq_r <= freq_dec; // RL1 RL2
      fast_osc_en_r <= !clk_stopped && !slow_sel;
    end
  end

  // ------------------------------------------------------------
  // clock status toward the rest of the chip
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk_stat_r <= '0;
    end else begin
      clk_stat_r.sys_clk_en <= !clk_stopped;
      clk_stat_r.cpu_run <= (mode_r == SCM_MODE_NORMAL) || (mode_r == SCM_MODE_SLOW); // RL12
      clk_stat_r.periph_slow_clk <= 1'b1; // RL4
      clk_stat_r.fast_osc_en <= !clk_stopped && !slow_sel;
      clk_stat_r.fast_freq <= freq_dec; // RL2
    end
  end

endmodule // scm_clock_mode_ctrl

// file: core/scm_pkg.sv
// package of constants and types for the system clock mode control block
package scm_pkg;

  // register map (byte addresses, one 32-bit word each)
  localparam logic [3:0] SCM_ADDR_FREQ_CTRL = 4'h0;
  localparam logic [3:0] SCM_ADDR_MODE = 4'h4;
  localparam logic [3:0] SCM_ADDR_AUX = 4'h8;
  localparam logic [3:0] SCM_ADDR_STATUS = 4'hc;

  // frequency control register fields
  localparam int SCM_FC_PIN_RESET_POS = 7;
  localparam int SCM_FC_SEL_LO_POS = 4;
  localparam logic [1:0] SCM_FC_SEL_RST = 2'h0;
  localparam logic [1:0] SCM_FC_RSV_RST = 2'h0;
  localparam logic SCM_FC_PIN_RESET_RST = 1'h0;

  // mode register fields
  localparam int SCM_MD_DIV_LO_POS = 5;
  localparam int SCM_MD_SPARE_POS = 4;
  localparam int SCM_MD_SLOW_RDY_POS = 3;
  localparam int SCM_MD_FAST_RDY_POS = 2;
  localparam int SCM_MD_IDLE_SEL_POS = 1;
  localparam int SCM_MD_DIRECT_POS = 0;
  localparam logic [2:0] SCM_MD_DIV_RST = 3'h0;
  localparam logic SCM_MD_SPARE_RST = 1'h0;
  localparam logic SCM_MD_IDLE_SEL_RST = 1'h1;
  localparam logic SCM_MD_DIRECT_RST = 1'h1;
  localparam logic SCM_IDLE_KEEP_RST = 1'h0;

  // fast oscillator frequency codes
  localparam logic [1:0] SCM_FREQ_8M = 2'h0;
  localparam logic [1:0] SCM_FREQ_16M = 2'h1;
  localparam logic [1:0] SCM_FREQ_12M = 2'h2;

  // fast ready delay after wake-up, 15 to 16 clock cycles
  localparam logic [4:0] SCM_FAST_WAKE_CYC = 5'h0f;

  // operating modes
  typedef enum logic [2:0] {
    SCM_MODE_NORMAL = 3'b000,
    SCM_MODE_SLOW = 3'b001,
    SCM_MODE_IDLE_STOP = 3'b010,
    SCM_MODE_IDLE_RUN = 3'b011,
    SCM_MODE_SLEEP = 3'b100
  } scm_mode_t;

  // clock status toward the rest of the chip
  typedef struct packed {
    logic sys_clk_en;
    logic cpu_run;
    logic periph_slow_clk;
    logic fast_osc_en;
    logic [1:0] fast_freq;
  } scm_clk_stat_t;

endpackage

// file: testbench/scm_asserts.sv
// port checker for the clock mode control block
module scm_asserts
  import scm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // watched ports
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic sys_clk_en_r,
  input wire logic slow_clk_en_r,
  input wire logic [1:0] fast_freq_r,
  input wire scm_mode_t mode_r,
  input wire scm_clk_stat_t clk_stat_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // properties
  // ----------------
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic run;
  assign run = mode_r inside {SCM_MODE_NORMAL, SCM_MODE_SLOW};
  property p_slow; !$past(sys_rst) |-> slow_clk_en_r; endproperty
  a_slow: assert property (p_slow) else $error("slow clock off");
  property p_periph; !$past(sys_rst) && !$past(sys_rst, 2) |-> clk_stat_r.periph_slow_clk; endproperty
  a_periph: assert property (p_periph) else $error("peripheral slow clock off");
  property p_freq; fast_freq_r != 2'h3 && clk_stat_r.fast_freq != 2'h3; endproperty
  a_freq: assert property (p_freq) else $error("bad frequency code");
  property p_halt; halt_req && run |=> !run; endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
  property p_wake; wake_req && !run |=> run; endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_sleep; mode_r == SCM_MODE_SLEEP && $past(mode_r) == SCM_MODE_SLEEP |-> !sys_clk_en_r; endproperty
  a_sleep: assert property (p_sleep) else $error("clock runs in sleep");
  property p_idle_clock_stopped_mode; $stable(mode_r) && mode_r == SCM_MODE_IDLE_STOP |-> !sys_clk_en_r; endproperty
  a_idle_clock_stopped_mode: assert property (p_idle_clock_stopped_mode) else $error("clock runs in stopped idle");
  property p_cpu; !$past(sys_rst) && $stable(mode_r) |-> clk_stat_r.cpu_run == run; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu run state wrong");
  c_sleep: cover property (mode_r == SCM_MODE_SLEEP);
  c_idle_clock_stopped_mode: cover property (mode_r == SCM_MODE_IDLE_STOP);
  c_idle_clock_running_mode: cover property (mode_r == SCM_MODE_IDLE_RUN);
endmodule // scm_asserts

bind scm_clock_mode_ctrl scm_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst), .halt_req(halt_req),
  .wake_req(wake_req), .sys_clk_en_r(sys_clk_en_r), .slow_clk_en_r(slow_clk_en_r),
  .fast_freq_r(fast_freq_r), .mode_r(mode_r), .clk_stat_r(clk_stat_r));

// file: testbench/scm_cpu_model.sv
// cpu core model: register bus master and halt/wake events
module scm_cpu_model
  import scm_pkg::*;
(
  // clock
  input wire logic mclk,
  // register bus master
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // cpu events
  output logic halt_req,
  output logic wake_req,
  output logic tmo
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // bus tasks
  // ----------------
  initial {avs_address, avs_read, avs_write, avs_writedata, avs_byteenable, halt_req, wake_req, tmo} = '0;
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    if (avs_waitrequest !== 1'b0) tmo <= 1'b1;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    acc(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  // frequency write keeping the two low bits
  task automatic fwr(input logic [1:0] c);
    logic [31:0] q;
    rd(SCM_ADDR_FREQ_CTRL, q);
    wr(SCM_ADDR_FREQ_CTRL, {26'h0, c, 2'h0, q[1:0]});
  endtask
  task automatic pulse(input logic h);
    @(posedge mclk);
    halt_req <= h;
    wake_req <= !h;
    @(posedge mclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask
endmodule // scm_cpu_model

// file: testbench/tb_scm_clock_mode_ctrl.sv
// testbench for the clock mode control block
module tb_scm_clock_mode_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import scm_pkg::*;
  logic mclk, sys_rst, slow_osc_stable, fast_osc_stable, pin_reset_evt, halt_req, wake_req, tmo;
  logic avs_read, avs_write, avs_waitrequest, sys_clk_en_r, slow_clk_en_r, fast_osc_en_r;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0] fast_freq_r;
  scm_mode_t mode_r;
  scm_clk_stat_t clk_stat_r;
  int errors, cmp_count, c;
  logic [1:0] ftab [4] = '{SCM_FREQ_8M, SCM_FREQ_16M, SCM_FREQ_12M, SCM_FREQ_8M};
  scm_mode_t htab [3] = '{SCM_MODE_SLEEP, SCM_MODE_IDLE_STOP, SCM_MODE_IDLE_RUN};
  // ----------------
  // instances and checks
  // ----------------
  scm_clock_mode_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halt_req(halt_req), .wake_req(wake_req),
    .slow_osc_stable(slow_osc_stable), .fast_osc_stable(fast_osc_stable), .pin_reset_evt(pin_reset_evt),
    .sys_clk_en_r(sys_clk_en_r), .slow_clk_en_r(slow_clk_en_r), .fast_freq_r(fast_freq_r),
    .fast_osc_en_r(fast_osc_en_r), .mode_r(mode_r), .clk_stat_r(clk_stat_r));
  scm_cpu_model cpu (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halt_req(halt_req), .wake_req(wake_req), .tmo(tmo));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkn(input string n, input int e, input int g);
    cmp_count++;
    if (g < e - 1 || g > e + 1) begin
      errors++;
      $display("BAD %s exp %0d got %0d", n, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task end_sim;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge tmo) begin
    errors++;
    end_sim();
  end
  initial begin
    {sys_rst, slow_osc_stable, fast_osc_stable, pin_reset_evt, errors, cmp_count} = {1'b1, 3'h0, 64'h0};
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    cpu.rd(SCM_ADDR_MODE, q);
    chk("mode reg", 32'h03, q);
    cpu.rd(SCM_ADDR_FREQ_CTRL, q);
    chk("freq reg", 32'h0, q);
    settle(1);
    chk("slow clk", 32'h1, slow_clk_en_r);
    chk("periph clk", 32'h1, clk_stat_r.periph_slow_clk);
    @(posedge mclk);
    slow_osc_stable <= 1'b1;
    fast_osc_stable <= 1'b1;
    settle(10);
    cpu.rd(SCM_ADDR_MODE, q);
    chk("ready flags", 32'h0f, q);
    cpu.wr(SCM_ADDR_MODE, 32'h10);
    cpu.rd(SCM_ADDR_MODE, q);
    chk("spare and flags", 32'h1c, q);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      cpu.fwr(i[1:0]);
      settle(2);
      chk("fast freq", {30'h0, ftab[i]}, fast_freq_r);
      cpu.rd(SCM_ADDR_FREQ_CTRL, q);
      chk("freq reg", {26'h0, i[1:0], 4'h0}, q);
    end
    $display("test freq done");
    for (int i = 0; i < 9; i++) begin
      cpu.wr(SCM_ADDR_MODE, (i == 8) ? 32'h01 : {24'h0, i[2:0], 5'h0});
      settle(4);
      c = 0;
      repeat (128) begin
        @(negedge mclk);
        c += (sys_clk_en_r === 1'b1);
      end
      chkn("clk enables", (i == 8) ? 128 : (i < 2) ? 0 : 1 << (i - 1), c);
      chk("mode", (i < 2) ? SCM_MODE_SLOW : SCM_MODE_NORMAL, mode_r);
      chk("fast osc en", {31'h0, i >= 2}, fast_osc_en_r);
    end
    $display("test divider done");
    for (int i = 0; i < 3; i++) begin
      cpu.wr(SCM_ADDR_AUX, {31'h0, i == 2});
      cpu.wr(SCM_ADDR_MODE, (i == 0) ? 32'h01 : 32'h03);
      cpu.pulse(1'b1);
      settle(3);
      chk("halt mode", htab[i], mode_r);
      chk("halt clk", {31'h0, i == 2}, sys_clk_en_r);
      chk("halt osc", {31'h0, i == 2}, fast_osc_en_r);
      cpu.rd(SCM_ADDR_MODE, q);
      if (i < 2) chk("rdy halted", 32'h0, q[2]);
      cpu.pulse(1'b0);
      cpu.rd(SCM_ADDR_MODE, q);
      if (i < 2) chk("rdy at wake", 32'h0, q[2]);
      settle(16);
      chk("woken mode", SCM_MODE_NORMAL, mode_r);
      cpu.rd(SCM_ADDR_MODE, q);
      chk("rdy after wake", 32'h1, q[2]);
    end
    $display("test halt done");
    @(posedge mclk);
    pin_reset_evt <= 1'b1;
    @(posedge mclk);
    pin_reset_evt <= 1'b0;
    cpu.rd(SCM_ADDR_FREQ_CTRL, q);
    chk("pin reset flag", 32'hb0, q);
    cpu.fwr(2'h0);
    cpu.rd(SCM_ADDR_FREQ_CTRL, q);
    chk("pin reset clear", 32'h0, q);
    $display("test pin reset done");
    cpu.rd(4'h1, q);
    chk("unmapped", 32'h0, q);
    end_sim();
  end
endmodule // tb_scm_clock_mode_ctrl
